// >>> design/posc_top.v
// power-on self-check sequencer with result code pins
// Operation
// RULE1 - fixture holds interrupt pin at twice supply, capture input high, then resets
// RULE2 - after reset the test sequence runs automatically and repeats forever
// RULE3 - good device flashes result pins; faulty device holds one steady pattern
// RULE4 - outcome shown as a four-bit code on the low port C pins
// RULE5 - low level on a result pin lights its indicator, high leaves it dark
// RULE6 - port fault 1001 or 0110, ram fault 1010, rom fault 1011
// RULE7 - timer fault 1100, serial fault 1101, converter fault 1110
// RULE8 - modulator fault 0001, interrupt fault 0010, watchdog fault 0011
// RULE9 - fixture treats any other steady pattern as a generally bad device
// RULE10 - the port test exercises all four parallel ports a to d
// RULE11 - ram test applies a counting test to every byte
// RULE12 - rom test xors all contents and checks for odd parity of ones
// RULE13 - timer test tracks counters and checks capture, compare, overflow flags
// RULE14 - serial test transmits then checks receive, transmit and framing flags
// RULE15 - converter test converts low reference, high reference and midpoint
// RULE16 - modulator test confirms basic operation of the modulation outputs
// RULE17 - interrupt test exercises external, timer and serial interrupt sources
// RULE18 - application code should not call the built-in self-check routines
// RULE19 - result pins are outputs, driven continuously during self-check
`timescale 1ns/10ps
`default_nettype none
`include "posc_map.vh"
module posc_top #(
  parameter        ROM_AW    = 8,
  parameter        RAM_AW    = 8,
  parameter [31:0] FLASH_CYC = `POSC_FLASH_CYC
) (
  input  wire        core_clk,
  input  wire        nrst,
  input  wire        self_check_mode,
  input  wire [7:0]  port_a_in,
  input  wire [7:0]  port_b_in,
  input  wire [7:0]  port_c_in,
  input  wire [7:0]  port_d_in,
  input  wire        capture_flag_one,
  input  wire        capture_flag_two,
  input  wire        compare_flag_one,
  input  wire        compare_flag_two,
  input  wire        timer_overflow_flag,
  input  wire [15:0] free_counter,
  input  wire [15:0] alt_counter,
  input  wire        receive_full_flag,
  input  wire        transmit_empty_flag,
  input  wire        transmit_complete_flag,
  input  wire        framing_error_flag,
  input  wire [7:0]  serial_rx_data,
  input  wire        adc_done,
  input  wire [7:0]  adc_result,
  input  wire        pulse_length_modulator_a,
  input  wire        pulse_length_modulator_b,
  input  wire        ext_irq_seen,
  input  wire        timer_irq_seen,
  input  wire        serial_irq_seen,
  input  wire        watchdog_bark,
  output reg  [7:0]  port_test_out,
  output reg         serial_tx_go,
  output reg  [7:0]  serial_tx_data,
  output reg         adc_start,
  output reg  [1:0]  adc_channel,
  output reg         irq_arm,
  output reg         wdog_starve,
  output reg  [3:0]  result_code_pins,
  output reg  [3:0]  result_code_pins_oe_n,
  output reg         check_running
);
  // =====================================================================
  // step sequencer states
  // a fault parks the sequencer until the next reset, so the code stays steady
  localparam ST_IDLE  = 2'h0;
  localparam ST_RUN   = 2'h1;
  localparam ST_WAIT  = 2'h2;
  localparam ST_FAULT = 2'h3;

  reg  [1:0]  state_r;
  reg  [3:0]  step_r;
  reg  [15:0] wait_r;
  reg  [1:0]  sub_r;
  reg  [7:0]  acc_r;
  reg  [3:0]  fault_code_r;
  reg  [31:0] flash_cnt_r;
  reg         flash_ph_r;
  reg  [7:0]  rom [0:(1<<ROM_AW)-1];
  reg  [ROM_AW-1:0] rom_addr_r;
  reg         ram_go_r;
  wire        ram_done;
  wire        ram_fail;
  reg         ok_nxt;
  reg         fin_nxt;
  reg  [3:0]  code_nxt;

  // self-check firmware image, a fixed constant table with odd parity overall
  integer k;
  initial begin
    for (k = 0; k < (1<<ROM_AW); k = k + 1) begin
      rom[k] = (k == 0) ? 8'h01 : 8'h00;
    end
  end

  posc_ram_check #(
    .AW (RAM_AW)
  ) u_ram (
    .core_clk (core_clk),
    .nrst     (nrst),
    .start    (ram_go_r),
    .done     (ram_done),
    .fail     (ram_fail)
  );

  // =====================================================================
  // per-step completion and pass decision
  always @* begin
    ok_nxt   = 1'b1;
    fin_nxt  = 1'b0;
    code_nxt = `POSC_CODE_DARK;
    case (step_r)
      `POSC_STEP_PORT: begin
        fin_nxt  = (sub_r == 2'h3);
        // port d is sampled on the finishing edge, so fold it in here
        ok_nxt   = ((acc_r | (port_d_in ^ port_test_out)) == 8'h00); // RULE10
        code_nxt = flash_ph_r ? `POSC_CODE_PORT_A : `POSC_CODE_PORT_B; // RULE6
      end
      `POSC_STEP_RAM: begin
        fin_nxt  = ram_done;
        ok_nxt   = !ram_fail;
        code_nxt = `POSC_CODE_RAM; // RULE6
      end
      `POSC_STEP_ROM: begin
        fin_nxt  = &rom_addr_r;
        ok_nxt   = ^(acc_r ^ rom[rom_addr_r]); // RULE12
        code_nxt = `POSC_CODE_ROM; // RULE6
      end
      `POSC_STEP_TIMER: begin
        fin_nxt  = capture_flag_one & capture_flag_two & compare_flag_one
                 & compare_flag_two & timer_overflow_flag; // RULE13
        ok_nxt   = (free_counter != alt_counter) || (free_counter != 16'h0000);
        code_nxt = `POSC_CODE_TIMER; // RULE7
      end
      `POSC_STEP_SERIAL: begin
        fin_nxt  = receive_full_flag & transmit_empty_flag & transmit_complete_flag;
        ok_nxt   = !framing_error_flag && (serial_rx_data == serial_tx_data); // RULE14
        code_nxt = `POSC_CODE_SERIAL; // RULE7
      end
      `POSC_STEP_ADC: begin
        fin_nxt  = adc_done && (sub_r == 2'h2);
        case (sub_r)
          2'h0:    ok_nxt = (adc_result <= 8'h01);
          2'h1:    ok_nxt = (adc_result >= 8'hfe);
          default: ok_nxt = (adc_result >= 8'h7e) && (adc_result <= 8'h81); // RULE15
        endcase
        code_nxt = `POSC_CODE_ADC; // RULE7
      end
      `POSC_STEP_PLM: begin
        fin_nxt  = (acc_r == 8'h0f); // both outputs seen high and low
        code_nxt = `POSC_CODE_PLM; // RULE8
      end
      `POSC_STEP_INTR: begin
        fin_nxt  = ext_irq_seen & timer_irq_seen & serial_irq_seen; // RULE17
        code_nxt = `POSC_CODE_INTR; // RULE8
      end
      default: begin
        fin_nxt  = watchdog_bark;
        code_nxt = `POSC_CODE_WDOG; // RULE8
      end
    endcase
  end

  // =====================================================================
  // sequencer: run each step, latch first fault, repeat forever
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_r        <= ST_IDLE;
      step_r         <= `POSC_STEP_PORT;
      sub_r          <= 2'h0;
      acc_r          <= 8'h00;
      wait_r         <= 16'h0000;
      rom_addr_r     <= {ROM_AW{1'b0}};
      ram_go_r       <= 1'b0;
      fault_code_r   <= `POSC_CODE_DARK;
      port_test_out  <= 8'h00;
      serial_tx_go   <= 1'b0;
      serial_tx_data <= 8'h00;
      adc_start      <= 1'b0;
      adc_channel    <= 2'h0;
      irq_arm        <= 1'b0;
      wdog_starve    <= 1'b0;
      check_running  <= 1'b0;
    end else begin
      ram_go_r     <= 1'b0;
      serial_tx_go <= 1'b0;
      adc_start    <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (self_check_mode) begin
            state_r       <= ST_RUN; // RULE2
            check_running <= 1'b1;
          end
        end
        ST_RUN: begin
          sub_r      <= 2'h0;
          acc_r      <= 8'h00;
          wait_r     <= 16'h0000;
          rom_addr_r <= {ROM_AW{1'b0}};
          irq_arm    <= (step_r == `POSC_STEP_INTR);
          wdog_starve <= (step_r == `POSC_STEP_WDOG);
          ram_go_r   <= (step_r == `POSC_STEP_RAM);
          serial_tx_go   <= (step_r == `POSC_STEP_SERIAL);
          serial_tx_data <= 8'h55 ^ {4'h0, step_r};
          adc_start   <= (step_r == `POSC_STEP_ADC);
          adc_channel <= 2'h0;
          port_test_out <= 8'haa;
          state_r <= ST_WAIT;
        end
        ST_WAIT: begin
          wait_r <= wait_r + 16'h0001;
          // per-step walking work
          case (step_r)
            `POSC_STEP_PORT: begin
              // each sub-step checks one port loops the pattern back
              case (sub_r)
                2'h0: acc_r <= acc_r | (port_a_in ^ port_test_out); // RULE10
                2'h1: acc_r <= acc_r | (port_b_in ^ port_test_out);
                2'h2: acc_r <= acc_r | (port_c_in ^ port_test_out);
                default: acc_r <= acc_r | (port_d_in ^ port_test_out);
              endcase
              sub_r <= sub_r + 2'h1;
            end
            `POSC_STEP_ROM: begin
              acc_r      <= acc_r ^ rom[rom_addr_r]; // RULE12
              rom_addr_r <= rom_addr_r + {{(ROM_AW-1){1'b0}}, 1'b1};
            end
            `POSC_STEP_ADC: begin
              if (adc_done && sub_r != 2'h2) begin
                if (!ok_nxt) begin
                  fault_code_r <= code_nxt;
                  state_r      <= ST_FAULT;
                end
                sub_r       <= sub_r + 2'h1;
                adc_channel <= sub_r + 2'h1; // low, high, midpoint
                adc_start   <= 1'b1;
              end
            end
            `POSC_STEP_PLM: begin
              acc_r <= acc_r | {4'h0, !pulse_length_modulator_b, pulse_length_modulator_b,
                                !pulse_length_modulator_a, pulse_length_modulator_a}; // RULE16
            end
            default: begin
            end
          endcase
          if (fin_nxt) begin
            if (!ok_nxt) begin
              fault_code_r <= code_nxt;
              state_r      <= ST_FAULT; // RULE3
            end else begin
              state_r <= ST_RUN;
              step_r  <= (step_r == `POSC_STEP_LAST) ? `POSC_STEP_PORT
                                                     : step_r + 4'h1; // RULE2
            end
          end else if (wait_r == `POSC_STEP_TMO) begin
            // a silent peripheral must not hang the loop with the pins flashing
            fault_code_r <= code_nxt; // no answer counts as a fault
            state_r      <= ST_FAULT;
          end
        end
        default: begin
          // fault held until the next reset
          irq_arm     <= 1'b0;
          wdog_starve <= 1'b0;
        end
      endcase
    end
  end

  // =====================================================================
  // flash divider for a good device
  // free running, so the flash rate does not depend on how long a step takes
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      flash_cnt_r <= 32'h0;
      flash_ph_r  <= 1'b0;
    end else if (flash_cnt_r >= FLASH_CYC - 32'h1) begin
      flash_cnt_r <= 32'h0;
      flash_ph_r  <= !flash_ph_r;
    end else begin
      flash_cnt_r <= flash_cnt_r + 32'h1;
    end
  end

  // =====================================================================
  // result pins: steady fault code or alternating pattern, driven while checking
  // pins float only while idle, so the fixture never reads a stale code
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      result_code_pins      <= `POSC_CODE_DARK; // RULE5
      result_code_pins_oe_n <= 4'hf;
    end else begin
      result_code_pins_oe_n <= check_running ? 4'h0 : 4'hf; // RULE19
      if (state_r == ST_FAULT) begin
        result_code_pins <= fault_code_r; // RULE3 RULE4
      end else if (check_running) begin
        result_code_pins <= flash_ph_r ? 4'h0 : 4'hf; // RULE3 RULE5
      end else begin
        result_code_pins <= `POSC_CODE_DARK;
      end
    end
  end
endmodule
`default_nettype wire

// >>> design/posc_map.vh
// constants for the power-on self-check sequencer
`ifndef POSC_MAP_VH
`define POSC_MAP_VH
// result codes, pin 3 down to pin 0, as driven on the pins (0 lights the indicator)
`define POSC_CODE_PORT_A   4'h9
`define POSC_CODE_PORT_B   4'h6
`define POSC_CODE_RAM      4'ha
`define POSC_CODE_ROM      4'hb
`define POSC_CODE_TIMER    4'hc
`define POSC_CODE_SERIAL   4'hd
`define POSC_CODE_ADC      4'he
`define POSC_CODE_PLM      4'h1
`define POSC_CODE_INTR     4'h2
`define POSC_CODE_WDOG     4'h3
`define POSC_CODE_DARK     4'hf
// test step numbers
`define POSC_STEP_PORT     4'h0
`define POSC_STEP_RAM      4'h1
`define POSC_STEP_ROM      4'h2
`define POSC_STEP_TIMER    4'h3
`define POSC_STEP_SERIAL   4'h4
`define POSC_STEP_ADC      4'h5
`define POSC_STEP_PLM      4'h6
`define POSC_STEP_INTR     4'h7
`define POSC_STEP_WDOG     4'h8
`define POSC_STEP_LAST     4'h8
// flash timing: one flash phase in us, cycles derived at 100 MHz
`define POSC_FLASH_US      100000
`define POSC_CLK_MHZ       100
`define POSC_FLASH_CYC     (`POSC_FLASH_US * `POSC_CLK_MHZ)
// longest wait for one test answer, in cycles
`define POSC_STEP_TMO      16'hffff
`endif

// >>> design/posc_ram_check.v
// counting test over every byte of a ram array
`timescale 1ns/10ps
`default_nettype none
module posc_ram_check #(
  parameter AW = 8
) (
  input  wire          core_clk,
  input  wire          nrst,
  input  wire          start,
  output reg           done,
  output reg           fail
);
  // =====================================================================
  // memory and walker
  reg  [7:0]    mem [0:(1<<AW)-1];
  reg  [AW-1:0] addr_r;
  reg  [1:0]    phase_r;
  reg           busy_r;
  // widen first so a narrow address never selects bits it does not have
  wire [AW+7:0] addr_ext = {8'h00, addr_r};
  wire [7:0]    pattern  = addr_ext[7:0] ^ {8{phase_r[1]}};

  // phase 0 writes the address count, phase 1 reads it back,
  // phase 2 writes its complement, phase 3 reads the complement
  always @(posedge core_clk) begin
    if (busy_r && !phase_r[0]) begin
      mem[addr_r] <= pattern;
    end
  end

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      addr_r  <= {AW{1'b0}};
      phase_r <= 2'h0;
      busy_r  <= 1'b0;
      done    <= 1'b0;
      fail    <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !busy_r) begin
        busy_r  <= 1'b1;
        addr_r  <= {AW{1'b0}};
        phase_r <= 2'h0;
        fail    <= 1'b0;
      end else if (busy_r) begin
        if (phase_r[0] && mem[addr_r] != pattern) begin
          fail <= 1'b1; // RULE11
        end
        addr_r <= addr_r + {{(AW-1){1'b0}}, 1'b1};
        if (&addr_r) begin
          phase_r <= phase_r + 2'h1;
          if (phase_r == 2'h3) begin
            busy_r <= 1'b0;
            done   <= 1'b1;
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> test/posc_top_asserts.sv
// checker on the result pins and step strobes of the self-check sequencer
`timescale 1ns/10ps
`default_nettype none
module posc_chk (
  input wire logic       core_clk,
  input wire logic       nrst,
  input wire logic       self_check_mode,
  input wire logic [7:0] port_test_out,
  input wire logic       serial_tx_go,
  input wire logic [7:0] serial_tx_data,
  input wire logic       adc_start,
  input wire logic [1:0] adc_channel,
  input wire logic       irq_arm,
  input wire logic       wdog_starve,
  input wire logic [3:0] result_code_pins,
  input wire logic [3:0] result_code_pins_oe_n,
  input wire logic       check_running
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // ====================================================
  // step sequences
  sequence s_tx_pulse;
    serial_tx_go ##1 !serial_tx_go;
  endsequence
  sequence s_driving;
    result_code_pins_oe_n == 4'h0;
  endsequence
  // ====================================================
  // properties
  a_pins_driven_soon: assert property ($rose(check_running) |-> ##[1:2] s_driving)
    else $error("result pins not driven after start");
  a_pins_stay_driven: assert property (s_driving |=> s_driving)
    else $error("result pins released while checking");
  a_code_is_legal: assert property (s_driving |-> result_code_pins inside
    {4'h0, 4'hf, 4'h9, 4'h6, 4'ha, 4'hb, 4'hc, 4'hd, 4'he, 4'h1, 4'h2, 4'h3})
    else $error("result pins show an unknown pattern");
  a_fault_held: assert property ((result_code_pins_oe_n == 4'h0) &&
    !(result_code_pins inside {4'h0, 4'hf})
    |=> $stable(result_code_pins)) else $error("fault code did not hold");
  a_tx_one_shot: assert property (serial_tx_go |-> s_tx_pulse)
    else $error("serial start longer than one cycle");
  a_tx_data_set: assert property (serial_tx_go |-> serial_tx_data == 8'h51)
    else $error("serial test byte wrong");
  a_port_pattern: assert property (s_driving |-> port_test_out == 8'haa)
    else $error("port test pattern wrong");
  a_adc_chan_ok: assert property (adc_start |-> adc_channel != 2'h3)
    else $error("converter channel out of range");
  a_steps_apart: assert property (!(irq_arm && wdog_starve))
    else $error("interrupt and watchdog steps overlap");
  a_idle_dark: assert property (!self_check_mode && !check_running |->
    result_code_pins == 4'hf && result_code_pins_oe_n == 4'hf && !adc_start && !serial_tx_go)
    else $error("idle device not dark");
endmodule
bind posc_top posc_chk u_chk (.core_clk, .nrst, .self_check_mode, .port_test_out,
  .serial_tx_go, .serial_tx_data, .adc_start, .adc_channel, .irq_arm, .wdog_starve,
  .result_code_pins, .result_code_pins_oe_n, .check_running);
`default_nettype wire

// >>> test/posc_fixture.sv
// peripherals and fixture around the sequencer, with selectable faults
`timescale 1ns/10ps
`default_nettype none
module posc_fixture (
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic [3:0]  fault_sel,
  input  wire logic [7:0]  port_test_out,
  input  wire logic        serial_tx_go,
  input  wire logic [7:0]  serial_tx_data,
  input  wire logic        adc_start,
  input  wire logic [1:0]  adc_channel,
  input  wire logic        irq_arm,
  input  wire logic        wdog_starve,
  output logic [7:0]       port_a_in,
  output logic [7:0]       port_b_in,
  output logic [7:0]       port_c_in,
  output logic [7:0]       port_d_in,
  output logic             capture_flag_one,
  output logic             capture_flag_two,
  output logic             compare_flag_one,
  output logic             compare_flag_two,
  output logic             timer_overflow_flag,
  output logic [15:0]      free_counter,
  output logic [15:0]      alt_counter,
  output logic             receive_full_flag,
  output logic             transmit_empty_flag,
  output logic             transmit_complete_flag,
  output logic             framing_error_flag,
  output logic [7:0]       serial_rx_data,
  output logic             adc_done,
  output logic [7:0]       adc_result,
  output logic             pulse_length_modulator_a,
  output logic             pulse_length_modulator_b,
  output logic             ext_irq_seen,
  output logic             timer_irq_seen,
  output logic             serial_irq_seen,
  output logic             watchdog_bark
);
  logic [15:0] cnt_r;
  logic        sent_r;
  logic        plm_r;
  // ports loop back, port b inverted when broken
  assign port_a_in = port_test_out;
  assign port_b_in = (fault_sel == 4'h1) ? ~port_test_out : port_test_out;
  assign port_c_in = port_test_out;
  assign port_d_in = port_test_out;
  // timer flags set, counters stuck at zero when broken
  assign {capture_flag_one, capture_flag_two, compare_flag_one} = 3'h7;
  assign {compare_flag_two, timer_overflow_flag} = 2'h3;
  assign free_counter = (fault_sel == 4'h3) ? 16'h0 : cnt_r;
  assign alt_counter = (fault_sel == 4'h3) ? 16'h0 : ~cnt_r;
  // serial flags follow a sent byte, framing error when broken
  assign {receive_full_flag, transmit_empty_flag, transmit_complete_flag} = {3{sent_r}};
  assign framing_error_flag = (fault_sel == 4'h4);
  assign pulse_length_modulator_a = plm_r;
  assign pulse_length_modulator_b = ~plm_r;
  // interrupt sources answer the arm, silent when broken
  assign {ext_irq_seen, timer_irq_seen, serial_irq_seen} =
    (fault_sel == 4'h7) ? 3'h0 : {3{irq_arm}};
  assign watchdog_bark = wdog_starve;
  // counter, echo and one-cycle converter
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= 16'h0;
      sent_r <= 1'b0;
      plm_r <= 1'b0;
      serial_rx_data <= 8'h0;
      adc_done <= 1'b0;
      adc_result <= 8'h0;
    end else begin
      cnt_r <= cnt_r + 16'h1;
      plm_r <= ~plm_r;
      // flags rise the cycle after a start and drop again, as for one byte
      sent_r <= serial_tx_go;
      if (serial_tx_go)
        serial_rx_data <= serial_tx_data;
      adc_done <= adc_start;
      if (adc_start)
        adc_result <= (adc_channel == 2'h0) ? 8'h00 : (adc_channel == 2'h1) ? 8'hff :
                      (fault_sel == 4'h5) ? 8'h40 : 8'h80;
      else
        adc_result <= ~adc_result;
    end
  end
endmodule
`default_nettype wire

// >>> test/power_on_self_check_tb.sv
// self-checking bench for the self-check sequencer
`timescale 1ns/10ps
`default_nettype none
module power_on_self_check_tb;
  logic        core_clk;
  logic        nrst;
  logic        self_check_mode;
  logic [3:0]  fault_sel;
  wire  [7:0]  port_a_in, port_b_in, port_c_in, port_d_in, port_test_out;
  wire  [7:0]  serial_rx_data, serial_tx_data, adc_result;
  wire  [15:0] free_counter, alt_counter;
  wire  [1:0]  adc_channel;
  wire  [3:0]  result_code_pins, result_code_pins_oe_n;
  wire         capture_flag_one, capture_flag_two, compare_flag_one, compare_flag_two;
  wire         timer_overflow_flag, receive_full_flag, transmit_empty_flag;
  wire         transmit_complete_flag, framing_error_flag, adc_done, watchdog_bark;
  wire         pulse_length_modulator_a, pulse_length_modulator_b, ext_irq_seen;
  wire         timer_irq_seen, serial_irq_seen, serial_tx_go, adc_start;
  wire         irq_arm, wdog_starve, check_running;
  int          n_errors = 0;
  int          samples_checked = 0;
  posc_top #(.ROM_AW(4), .RAM_AW(4), .FLASH_CYC(32'h4)) DUT (.*);
  posc_fixture u_fix (.*);
  // ====================================================
  // clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // compare tasks and closing report
  task automatic cmp4(input logic [3:0] got, input logic [3:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp1(input logic got, input logic exp);
    cmp4({3'h0, got}, {3'h0, exp});
  endtask
  task automatic complete_run;
    $display("checks=%0d errors=%0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // reset for ten cycles with the mode strap and fault choice
  task automatic start(input logic m, input logic [3:0] f);
    @(posedge core_clk);
    nrst <= 1'b0;
    self_check_mode <= m;
    fault_sel <= f;
    repeat (10) @(posedge core_clk);
    nrst <= 1'b1;
  endtask
  // ====================================================
  // scenarios
  task automatic t_idle;
    start(1'b0, 4'h0);
    repeat (20) @(negedge core_clk);
    cmp4(result_code_pins, 4'hf);
    cmp4(result_code_pins_oe_n, 4'hf);
    cmp1(check_running, 1'b0);
    $display("test idle done");
  endtask
  task automatic t_good;
    int pulses;
    bit lit;
    bit dark;
    pulses = 0;
    lit = 0;
    dark = 0;
    start(1'b1, 4'h0);
    for (int i = 0; i < 5000 && pulses < 3; i++) begin
      @(negedge core_clk);
      if (serial_tx_go === 1'b1) pulses++;
      if (result_code_pins === 4'h0) lit = 1;
      if (result_code_pins === 4'hf && result_code_pins_oe_n === 4'h0) dark = 1;
    end
    cmp1(pulses == 3, 1'b1);
    if (pulses < 3)
      complete_run();
    cmp1(lit && dark, 1'b1);
    cmp4(result_code_pins_oe_n, 4'h0);
    cmp1(port_test_out === 8'haa, 1'b1);
    $display("test good device done");
  endtask
  task automatic t_fault(input logic [3:0] f, input logic [3:0] exp, input int bound);
    int i;
    i = 0;
    start(1'b1, f);
    @(negedge core_clk);
    while (i < bound && result_code_pins inside {4'h0, 4'hf}) begin
      @(negedge core_clk);
      i++;
    end
    if (i >= bound) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, result_code_pins, exp);
      complete_run();
    end
    repeat (20) @(negedge core_clk);
    if (exp == 4'h9)
      cmp1(result_code_pins inside {4'h9, 4'h6}, 1'b1);
    else
      cmp4(result_code_pins, exp);
    $display("test fault %h done", f);
  endtask
  // ====================================================
  // main sequence
  initial begin
    nrst = 1'b0;
    self_check_mode = 1'b0;
    fault_sel = 4'h0;
    t_idle();
    t_good();
    t_fault(4'h1, 4'h9, 2000);
    t_fault(4'h3, 4'hc, 2000);
    t_fault(4'h4, 4'hd, 2000);
    t_fault(4'h5, 4'he, 2000);
    t_fault(4'h7, 4'h2, 70000);
    complete_run();
  end
endmodule
`default_nettype wire
